// [include/adcsq_pkg.sv]
// Constants, types and register layout for the converter sequencer.
// Assumes a byte-wide register port and one core clock for all logic.
// Notes on behaviour
// - Conversion clock is core clock divided by two to the power of a 3-bit code.
// - Reference code 00 picks supply, 01 picks reference pin, 1x picks amplifier.
// - Pin plus internal reference requested together: only the internal one is used.
// - Amplifier input bit low feeds the amp pin, high feeds the bandgap.
// - Amp pin and bandgap both requested: only the bandgap feeds the amplifier.
// - Source codes 0000, 0100, 1100 to 1111 convert the selected external channel.
// - Channel codes 0 to 11 pick pins 0 to 11; 12 to 15 leave input floating.
// - Source codes 0001 to 0011 pick supply scaled by one, half, quarter.
// - Source codes 0101 to 0111 pick amplifier output scaled by one, half, quarter.
// - Source codes 1000 to 1011 are reserved and tie the input to ground.
// - Any internal source disconnects every external channel.
// - A conversion takes 4 sampling plus 12 converting periods, 16 in all.
// - Converter circuitry is powered only while the power enable bit is high.
// - Start bit pulsed high then low; conversion begins on the falling edge.
// - Busy flag is high during conversion and clears when the result is ready.
// - A pin in analog mode loses other functions and its pull-up.
// - Analog mode on a pin overrides its port direction setting.
// - Align 0: high byte holds bits 11:4; align 1: high byte holds bits 11:8.
// - While the start bit stays high the converter is held in reset.
// - Completion sets the request flag and raises the interrupt when enabled.
// - Powering the converter down leaves both result registers unchanged.
package adcsq_pkg;

  localparam int unsigned RES_W     = 12;
  localparam int unsigned CHAN_NUM  = 12;
  localparam int unsigned ADDR_W    = 3;
  localparam int unsigned DATA_W    = 8;

  // Register byte offsets.
  localparam logic [2:0] ADDR_CTRL0   = 3'h0;
  localparam logic [2:0] ADDR_CTRL1   = 3'h1;
  localparam logic [2:0] ADDR_CTRL2   = 3'h2;
  localparam logic [2:0] ADDR_RES_HI  = 3'h3;
  localparam logic [2:0] ADDR_RES_LO  = 3'h4;
  localparam logic [2:0] ADDR_PINFS_L = 3'h5;
  localparam logic [2:0] ADDR_PINFS_H = 3'h6;
  localparam logic [2:0] ADDR_IRQ     = 3'h7;

  // Field positions inside the control bytes.
  localparam int unsigned C0_START = 7;
  localparam int unsigned C0_BUSY  = 6;
  localparam int unsigned C0_PWR   = 5;
  localparam int unsigned C0_ALIGN = 4;
  localparam int unsigned C0_CH    = 0;
  localparam int unsigned C1_SRC   = 4;
  localparam int unsigned C1_DIV   = 0;
  localparam int unsigned C2_AMPEN = 7;
  localparam int unsigned C2_AMPIN = 4;
  localparam int unsigned C2_REF   = 2;
  localparam int unsigned C2_GAIN  = 0;
  localparam int unsigned IRQ_GIE  = 2;
  localparam int unsigned IRQ_CIE  = 1;
  localparam int unsigned IRQ_FLAG = 0;
  localparam int unsigned PINFS_HW = 4;

  // Conversion timing in conversion-clock periods.
  localparam int unsigned SAMPLE_PERIODS  = 4;
  localparam int unsigned CONVERT_PERIODS = 12;
  localparam int unsigned TOTAL_PERIODS   = SAMPLE_PERIODS + CONVERT_PERIODS;
  localparam logic [3:0]  LAST_SAMPLE     = 4'(SAMPLE_PERIODS - 1);
  localparam logic [3:0]  LAST_PERIOD     = 4'(TOTAL_PERIODS - 1);
  localparam logic [11:0] SAR_MSB         = 12'h800;

  // Reference selection one-hot positions and codes.
  localparam int unsigned REF_SUPPLY = 0;
  localparam int unsigned REF_PIN    = 1;
  localparam int unsigned REF_AMP    = 2;
  localparam logic [1:0]  REFC_SUPPLY = 2'h0;
  localparam logic [1:0]  REFC_PIN    = 2'h1;

  typedef enum logic [1:0] {
    KIND_EXT    = 2'h0,
    KIND_SUPPLY = 2'h1,
    KIND_AMP    = 2'h2,
    KIND_GND    = 2'h3
  } adcsq_kind_t;

  typedef enum logic [1:0] {
    SCALE_1       = 2'h0,
    SCALE_HALF    = 2'h1,
    SCALE_QUARTER = 2'h2
  } adcsq_scale_t;

  typedef enum logic [1:0] {
    PH_IDLE    = 2'h0,
    PH_SAMPLE  = 2'h1,
    PH_CONVERT = 2'h3,
    PH_HOLD    = 2'h2
  } adcsq_phase_t;

  typedef struct packed {
    adcsq_kind_t  kind;
    adcsq_scale_t scale;
  } adcsq_src_t;

  // Analog switch controls towards the converter core.
  typedef struct packed {
    logic [2:0]          ref_sel;
    logic                amp_pin;
    logic                amp_bandgap;
    adcsq_src_t          src;
    logic [CHAN_NUM-1:0] chan_en;
    logic                sample;
    logic [RES_W-1:0]    code;
  } adcsq_analog_t;

  // Per-pin overrides towards the port logic.
  typedef struct packed {
    logic [CHAN_NUM-1:0] analog;
    logic [CHAN_NUM-1:0] pullup_en;
    logic [CHAN_NUM-1:0] drive_en;
  } adcsq_pin_t;

endpackage : adcsq_pkg

// [hw/adcsq_clkdiv.sv]
// Conversion clock divider: a one-cycle tick every 2**sel core cycles.
// Assumes restart and sel come from logic on the same core clock.
`timescale 1ns/1ns
module adcsq_clkdiv #(
  parameter int unsigned SEL_W = 3
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             restart_in,
  input  wire logic [SEL_W-1:0] sel_in,
  output logic                  tick_out
);

  localparam int unsigned CNT_W = (1 << SEL_W) - 1;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
  } adcsq_div_state_t;

  adcsq_div_state_t st;
  adcsq_div_state_t next_st;
  logic [CNT_W-1:0] limit;

  // Terminal count is 2**sel minus one, so code zero ticks every cycle.
  always_comb
  begin
    limit    = CNT_W'((1 << sel_in) - 1);
    tick_out = (st.cnt == limit);
    next_st  = st;
    if (restart_in || tick_out)
    begin
      next_st.cnt = '0;
    end
    else
    begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  // Restart aligns the first period to the start of a conversion.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st <= '0;
    end
    else if (ce_in)
    begin
      st <= next_st;
    end
  end

endmodule : adcsq_clkdiv

// [hw/adcsq_top.sv]
// Sequencer and control registers of a 12-bit successive-approximation converter.
// Assumes a byte register port on the core clock and an asynchronous comparator input.
`timescale 1ns/1ns
module adcsq_top (
  input  wire logic                                CORE_CLK_IN,
  input  wire logic                                RST_IN,
  input  wire logic                                CLK_EN_IN,
  input  wire logic [adcsq_pkg::ADDR_W-1:0]        REG_ADDR_IN,
  input  wire logic [adcsq_pkg::DATA_W-1:0]        REG_WDATA_IN,
  input  wire logic                                REG_WR_IN,
  input  wire logic                                REG_RD_IN,
  input  wire logic                                COMP_IN,
  input  wire logic [adcsq_pkg::CHAN_NUM-1:0]      PULLUP_REQ_IN,
  input  wire logic [adcsq_pkg::CHAN_NUM-1:0]      DRIVE_REQ_IN,
  output logic      [adcsq_pkg::DATA_W-1:0]        REG_RDATA_OUT,
  output adcsq_pkg::adcsq_analog_t                 ANALOG_OUT,
  output adcsq_pkg::adcsq_pin_t                    PIN_OUT,
  output logic                                     CONV_POWER_OUT,
  output logic                                     AMP_POWER_OUT,
  output logic      [1:0]                          AMP_GAIN_OUT,
  output logic                                     BUSY_OUT,
  output logic                                     IRQ_OUT
);

  typedef struct packed {
    logic                           start;
    logic                           power_en;
    logic                           align;
    logic [3:0]                     ch;
    logic [3:0]                     src;
    logic [2:0]                     div;
    logic [2:0]                     run_div;
    logic                           amp_pwr;
    logic                           amp_sel;
    logic [1:0]                     ref_sel;
    logic [1:0]                     gain;
    logic [adcsq_pkg::CHAN_NUM-1:0] pinfs;
    logic                           gie;
    logic                           cie;
    logic                           flag;
    logic [adcsq_pkg::RES_W-1:0]    result;
    logic                           busy;
    adcsq_pkg::adcsq_phase_t        phase;
    logic [3:0]                     period;
    logic [adcsq_pkg::RES_W-1:0]    trial;
    logic [adcsq_pkg::RES_W-1:0]    mask;
    logic                           comp_s1;
    logic                           comp_s2;
    logic [adcsq_pkg::DATA_W-1:0]   rdata;
    logic                           irq;
    adcsq_pkg::adcsq_analog_t       ana;
    adcsq_pkg::adcsq_pin_t          pin;
  } adcsq_state_t;

  adcsq_state_t                st;
  adcsq_state_t                next_st;
  logic                        tick;
  logic                        launch;
  logic [adcsq_pkg::RES_W-1:0] decided;

  // Source code to switch kind and scale.
  function automatic adcsq_pkg::adcsq_src_t src_decode(input logic [3:0] code);
    adcsq_pkg::adcsq_src_t s;
    s.scale = adcsq_pkg::adcsq_scale_t'(code[1:0] - 2'h1);
    case (code[3:2])
      2'h0:    s.kind = (code[1:0] == 2'h0) ? adcsq_pkg::KIND_EXT : adcsq_pkg::KIND_SUPPLY;
      2'h1:    s.kind = (code[1:0] == 2'h0) ? adcsq_pkg::KIND_EXT : adcsq_pkg::KIND_AMP;
      2'h2:    s.kind = adcsq_pkg::KIND_GND;
      default: s.kind = adcsq_pkg::KIND_EXT;
    endcase
    if (s.kind == adcsq_pkg::KIND_EXT || s.kind == adcsq_pkg::KIND_GND)
    begin
      s.scale = adcsq_pkg::SCALE_1;
    end
    return s;
  endfunction : src_decode

  // Reference code to one-hot switch; the pin wins only when alone.
  function automatic logic [2:0] ref_decode(input logic [1:0] code);
    logic [2:0] r;
    r = '0;
    case (code)
      adcsq_pkg::REFC_SUPPLY: r[adcsq_pkg::REF_SUPPLY] = 1'b1;
      adcsq_pkg::REFC_PIN:    r[adcsq_pkg::REF_PIN]    = 1'b1;
      default:                r[adcsq_pkg::REF_AMP]    = 1'b1;
    endcase
    return r;
  endfunction : ref_decode

  // The divider takes the division latched at launch, so a mid-conversion
  // write to the divider field cannot stretch or cut the running conversion.
  adcsq_clkdiv #(
    .SEL_W (3)
  ) u_div (
    .clk_in     (CORE_CLK_IN),
    .rst_in     (RST_IN),
    .ce_in      (CLK_EN_IN),
    .restart_in (launch),
    .sel_in     (st.run_div),
    .tick_out   (tick)
  );

  // Register writes, read answer, sequencer and registered outputs.
  always_comb
  begin
    next_st       = st;
    launch        = 1'b0;
    next_st.rdata = '0;
    decided       = st.comp_s2 ? st.trial : (st.trial & ~st.mask);

    // Only the second synchroniser stage is ever read.
    next_st.comp_s1 = COMP_IN;
    next_st.comp_s2 = st.comp_s1;

    if (REG_WR_IN)
    begin
      case (REG_ADDR_IN)
        adcsq_pkg::ADDR_CTRL0:
        begin
          next_st.start    = REG_WDATA_IN[adcsq_pkg::C0_START];
          next_st.power_en = REG_WDATA_IN[adcsq_pkg::C0_PWR];
          next_st.align    = REG_WDATA_IN[adcsq_pkg::C0_ALIGN];
          next_st.ch       = REG_WDATA_IN[adcsq_pkg::C0_CH +: 4];
        end
        adcsq_pkg::ADDR_CTRL1:
        begin
          next_st.src = REG_WDATA_IN[adcsq_pkg::C1_SRC +: 4];
          next_st.div = REG_WDATA_IN[adcsq_pkg::C1_DIV +: 3];
        end
        adcsq_pkg::ADDR_CTRL2:
        begin
          next_st.amp_pwr = REG_WDATA_IN[adcsq_pkg::C2_AMPEN];
          next_st.amp_sel = REG_WDATA_IN[adcsq_pkg::C2_AMPIN];
          next_st.ref_sel = REG_WDATA_IN[adcsq_pkg::C2_REF +: 2];
          next_st.gain    = REG_WDATA_IN[adcsq_pkg::C2_GAIN +: 2];
        end
        adcsq_pkg::ADDR_PINFS_L:
          next_st.pinfs[adcsq_pkg::DATA_W-1:0] = REG_WDATA_IN;
        adcsq_pkg::ADDR_PINFS_H:
          next_st.pinfs[adcsq_pkg::CHAN_NUM-1:adcsq_pkg::DATA_W] =
            REG_WDATA_IN[adcsq_pkg::PINFS_HW-1:0];
        adcsq_pkg::ADDR_IRQ:
        begin
          next_st.gie  = REG_WDATA_IN[adcsq_pkg::IRQ_GIE];
          next_st.cie  = REG_WDATA_IN[adcsq_pkg::IRQ_CIE];
          next_st.flag = REG_WDATA_IN[adcsq_pkg::IRQ_FLAG];
        end
        default: ;
      endcase
    end

    // Result bytes are formatted at read time from one 12-bit word.
    if (REG_RD_IN)
    begin
      case (REG_ADDR_IN)
        adcsq_pkg::ADDR_CTRL0:
          next_st.rdata = {st.start, st.busy, st.power_en, st.align, st.ch};
        adcsq_pkg::ADDR_CTRL1:
          next_st.rdata = {st.src, 1'b0, st.div};
        adcsq_pkg::ADDR_CTRL2:
          next_st.rdata = {st.amp_pwr, 2'h0, st.amp_sel, st.ref_sel, st.gain};
        adcsq_pkg::ADDR_RES_HI:
          next_st.rdata = st.align ? {4'h0, st.result[11:8]} : st.result[11:4];
        adcsq_pkg::ADDR_RES_LO:
          next_st.rdata = st.align ? st.result[7:0] : {st.result[3:0], 4'h0};
        adcsq_pkg::ADDR_PINFS_L:
          next_st.rdata = st.pinfs[adcsq_pkg::DATA_W-1:0];
        adcsq_pkg::ADDR_PINFS_H:
          next_st.rdata = {4'h0, st.pinfs[adcsq_pkg::CHAN_NUM-1:adcsq_pkg::DATA_W]};
        default:
          next_st.rdata = {5'h00, st.gie, st.cie, st.flag};
      endcase
    end

    // Sequencer; start high always wins and parks the converter in reset.
    case (st.phase)
      adcsq_pkg::PH_IDLE:
        if (next_st.start)
        begin
          next_st.phase = adcsq_pkg::PH_HOLD;
        end
      adcsq_pkg::PH_HOLD:
        if (!next_st.start)
        begin
          next_st.phase = adcsq_pkg::PH_IDLE;
          if (next_st.power_en)
          begin
            launch          = 1'b1;
            next_st.run_div = next_st.div;
            next_st.phase   = adcsq_pkg::PH_SAMPLE;
            next_st.period  = '0;
            next_st.busy    = 1'b1;
          end
        end
      adcsq_pkg::PH_SAMPLE:
        if (tick)
        begin
          next_st.period = st.period + 4'h1;
          if (st.period == adcsq_pkg::LAST_SAMPLE)
          begin
            next_st.phase = adcsq_pkg::PH_CONVERT;
            next_st.trial = adcsq_pkg::SAR_MSB;
            next_st.mask  = adcsq_pkg::SAR_MSB;
          end
        end
      adcsq_pkg::PH_CONVERT:
        if (tick)
        begin
          next_st.period = st.period + 4'h1;
          next_st.mask   = st.mask >> 1;
          next_st.trial  = decided | (st.mask >> 1);
          if (st.period == adcsq_pkg::LAST_PERIOD)
          begin
            next_st.phase  = adcsq_pkg::PH_IDLE;
            next_st.result = decided;
            next_st.busy   = 1'b0;
            next_st.flag   = 1'b1;
          end
        end
      default:
        next_st.phase = adcsq_pkg::PH_IDLE;
    endcase

    // Abort keeps the old result: power-down and a new start pulse cut the run.
    if (st.busy && (!next_st.power_en || next_st.start))
    begin
      next_st.busy   = 1'b0;
      next_st.result = st.result;
      next_st.phase  = next_st.start ? adcsq_pkg::PH_HOLD : adcsq_pkg::PH_IDLE;
    end

    next_st.irq = next_st.flag && next_st.gie && next_st.cie;

    // Switch controls follow the next register values so they stay registered.
    next_st.ana.ref_sel     = ref_decode(next_st.ref_sel);
    next_st.ana.amp_pin     = !next_st.amp_sel;
    next_st.ana.amp_bandgap = next_st.amp_sel;
    next_st.ana.src         = src_decode(next_st.src);
    next_st.ana.chan_en     = '0;
    if (next_st.ana.src.kind == adcsq_pkg::KIND_EXT &&
        next_st.ch < 4'(adcsq_pkg::CHAN_NUM))
    begin
      next_st.ana.chan_en = adcsq_pkg::CHAN_NUM'(1) << next_st.ch;
    end
    next_st.ana.sample = (next_st.phase == adcsq_pkg::PH_SAMPLE);
    next_st.ana.code   = next_st.trial;

    // Analog mode strips pull-up and output drive whatever the port asks.
    next_st.pin.analog    = next_st.pinfs;
    next_st.pin.pullup_en = PULLUP_REQ_IN & ~next_st.pinfs;
    next_st.pin.drive_en  = DRIVE_REQ_IN & ~next_st.pinfs;
  end

  // All state advances only while the clock enable is high.
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      st <= '0;
    end
    else if (CLK_EN_IN)
    begin
      st <= next_st;
    end
  end

  // Every output is a flip-flop of the state word.
  assign REG_RDATA_OUT  = st.rdata;
  assign ANALOG_OUT     = st.ana;
  assign PIN_OUT        = st.pin;
  assign CONV_POWER_OUT = st.power_en;
  assign AMP_POWER_OUT  = st.amp_pwr;
  assign AMP_GAIN_OUT   = st.gain;
  assign BUSY_OUT       = st.busy;
  assign IRQ_OUT        = st.irq;

  // Busy length counter, read only by the checks below.
  logic [11:0] busy_len;
  always_ff @(posedge CORE_CLK_IN)
  begin
    if (RST_IN)
    begin
      busy_len <= '0;
    end
    else if (CLK_EN_IN)
    begin
      busy_len <= st.busy ? busy_len + 12'h001 : 12'h000;
    end
  end

  default clocking adcsq_cb @(posedge CORE_CLK_IN iff CLK_EN_IN);
  endclocking
  default disable iff (RST_IN);

  conv_length_a: assert property (
    $fell(st.busy) && !st.start && st.power_en |->
      $past(busy_len) + 12'h001 == (12'(adcsq_pkg::TOTAL_PERIODS) << st.run_div))
    else $error("Conversion length does not match sixteen divided periods.");

  ref_route_a: assert property (
    !$past(RST_IN) |-> $onehot(ANALOG_OUT.ref_sel) &&
    (ANALOG_OUT.ref_sel[adcsq_pkg::REF_PIN] == (st.ref_sel == adcsq_pkg::REFC_PIN)))
    else $error("Reference routing is not exclusive.");

  amp_source_a: assert property (
    !$past(RST_IN) |-> ANALOG_OUT.amp_pin != st.amp_sel && ANALOG_OUT.amp_bandgap == st.amp_sel)
    else $error("Amplifier input routing is wrong.");

  ext_off_a: assert property (
    (!(st.src inside {4'h0, 4'h4, [4'hc:4'hf]}) || st.ch >= 4'(adcsq_pkg::CHAN_NUM))
      |-> ANALOG_OUT.chan_en == '0)
    else $error("External channel connected while deselected.");

  start_launch_a: assert property (
    $fell(st.start) && st.power_en |-> st.busy && st.phase == adcsq_pkg::PH_SAMPLE)
    else $error("Falling start did not launch a conversion.");

  hold_reset_a: assert property (
    st.start |-> !st.busy && st.phase == adcsq_pkg::PH_HOLD)
    else $error("Converter not held in reset while start is high.");

  power_keep_a: assert property (
    !st.power_en |-> !st.busy ##1 $stable(st.result))
    else $error("Result changed or busy set while powered down.");

  done_flag_a: assert property (
    $fell(st.busy) && !st.start && st.power_en |-> st.flag ##1 (IRQ_OUT || !(st.gie && st.cie)))
    else $error("Completion did not set the request flag.");

  pin_override_a: assert property (
    ((PIN_OUT.pullup_en | PIN_OUT.drive_en) & PIN_OUT.analog) == '0)
    else $error("Analog pin still has pull-up or drive.");

  read_align_a: assert property (
    REG_RD_IN && REG_ADDR_IN == adcsq_pkg::ADDR_RES_HI && st.align |=>
      REG_RDATA_OUT[7:4] == 4'h0)
    else $error("Right-aligned high byte has upper bits set.");

  conv_done_c: cover property ($fell(st.busy) && st.flag);
  abort_start_c: cover property (st.busy ##1 st.start);
  slow_div_c: cover property ($fell(st.busy) && st.run_div == 3'h7);
  irq_raise_c: cover property ($rose(IRQ_OUT));

endmodule : adcsq_top

// [sim/adcsq_top_tb_top.sv]
// Self-checking bench for the converter sequencer: registers, input selection and timing.
// Assumes the design package is compiled first; the comparator is held at one level per run.
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("MISMATCH t=%0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end

module adcsq_top_tb_top;
  logic                           clk;
  logic                           rst;
  logic                           clk_en;
  logic [adcsq_pkg::ADDR_W-1:0]   addr;
  logic [adcsq_pkg::DATA_W-1:0]   wdata;
  logic                           wr;
  logic                           rd;
  logic                           comp;
  logic [adcsq_pkg::CHAN_NUM-1:0] pullup_req;
  logic [adcsq_pkg::CHAN_NUM-1:0] drive_req;
  logic [adcsq_pkg::DATA_W-1:0]   rdata;
  adcsq_pkg::adcsq_analog_t       analog;
  adcsq_pkg::adcsq_pin_t          pin;
  logic                           conv_pwr;
  logic                           amp_pwr;
  logic [1:0]                     amp_gain;
  logic                           busy;
  logic                           irq;
  int                             error_cnt;
  int                             check_count;
  int                             cyc;
  int                             seed;
  logic [7:0]                     rval;
  logic [11:0]                    res;
  logic [11:0]                    fs;
  logic [3:0]                     ch;

  adcsq_top u_dut (
    .CORE_CLK_IN   (clk),
    .RST_IN        (rst),
    .CLK_EN_IN     (clk_en),
    .REG_ADDR_IN   (addr),
    .REG_WDATA_IN  (wdata),
    .REG_WR_IN     (wr),
    .REG_RD_IN     (rd),
    .COMP_IN       (comp),
    .PULLUP_REQ_IN (pullup_req),
    .DRIVE_REQ_IN  (drive_req),
    .REG_RDATA_OUT (rdata),
    .ANALOG_OUT    (analog),
    .PIN_OUT       (pin),
    .CONV_POWER_OUT(conv_pwr),
    .AMP_POWER_OUT (amp_pwr),
    .AMP_GAIN_OUT  (amp_gain),
    .BUSY_OUT      (busy),
    .IRQ_OUT       (irq)
  );

  // Free-running 125 MHz core clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Prints the verdict and ends the run; also reached when the cycle limit runs out.
  task automatic report_and_stop();
    if (error_cnt == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  // A hang would otherwise never end, so the run is capped well above its real length.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      report_and_stop();
    end
  end

  // One-cycle register write, strobe raised just after a rising edge.
  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  // One-cycle register read; the data stand only in the cycle after the strobe.
  task automatic reg_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // Expected source kind for an input-source code.
  function automatic logic [1:0] exp_kind(input logic [3:0] s);
    if (s == 4'h0 || s == 4'h4 || s >= 4'hc)
      return 2'h0;
    if (s >= 4'h1 && s <= 4'h3)
      return 2'h1;
    if (s >= 4'h5 && s <= 4'h7)
      return 2'h2;
    return 2'h3;
  endfunction : exp_kind

  // Full conversion: power up, settle, start pulse, then timing, result and interrupt checks.
  task automatic run_conv(input logic [2:0] div, input logic al, input logic c, input logic ie);
    int n;
    res = {12{c}};
    comp <= c;
    reg_wr(adcsq_pkg::ADDR_CTRL1, {5'h00, div});
    reg_wr(adcsq_pkg::ADDR_IRQ, {5'h00, ie, ie, 1'b0});
    reg_wr(adcsq_pkg::ADDR_CTRL0, {3'h1, al, 4'h0});
    repeat (8) @(posedge clk);
    reg_wr(adcsq_pkg::ADDR_CTRL0, {3'h5, al, 4'h0});
    repeat (3) @(posedge clk);
    #1;
    `CHK(busy, 1'b0);
    reg_wr(adcsq_pkg::ADDR_CTRL0, {3'h1, al, 4'h0});
    #1;
    `CHK({busy, analog.sample}, 2'h3);
    n = 0;
    while (busy === 1'b1 && n < 5000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHK(n, 16 << div);
    `CHK({analog.sample, analog.code}, {1'b0, res});
    @(posedge clk);
    #1;
    `CHK(irq, ie);
    reg_rd(adcsq_pkg::ADDR_RES_HI, rval);
    `CHK(rval, al ? {4'h0, res[11:8]} : res[11:4]);
    reg_rd(adcsq_pkg::ADDR_RES_LO, rval);
    `CHK(rval, al ? res[7:0] : {res[3:0], 4'h0});
    reg_rd(adcsq_pkg::ADDR_IRQ, rval);
    `CHK(rval, {5'h00, ie, ie, 1'b1});
    reg_wr(adcsq_pkg::ADDR_IRQ, 8'h00);
    @(posedge clk);
    #1;
    `CHK(irq, 1'b0);
  endtask : run_conv

  // Main sequence: reset, register access, selection tables, pins, conversions, abort.
  initial
  begin
    seed = 90234;
    clk_en = 1'b1;
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    comp = 1'b0;
    pullup_req = '0;
    drive_req = '0;
    error_cnt = 0;
    check_count = 0;
    cyc = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(analog.ref_sel, 3'h1);
    for (int a = 0; a < 8; a++)
    begin
      reg_rd(a[2:0], rval);
      `CHK(rval, 8'h00);
    end
    // Read-only and unimplemented bits must not take written ones.
    reg_wr(adcsq_pkg::ADDR_CTRL0, 8'h4f);
    reg_wr(adcsq_pkg::ADDR_CTRL1, 8'hff);
    reg_wr(adcsq_pkg::ADDR_CTRL2, 8'hff);
    reg_wr(adcsq_pkg::ADDR_RES_HI, 8'h55);
    reg_rd(adcsq_pkg::ADDR_CTRL0, rval);
    `CHK(rval, 8'h0f);
    reg_rd(adcsq_pkg::ADDR_CTRL1, rval);
    `CHK(rval, 8'hf7);
    reg_rd(adcsq_pkg::ADDR_CTRL2, rval);
    `CHK(rval, 8'h9f);
    reg_rd(adcsq_pkg::ADDR_RES_HI, rval);
    `CHK(rval, 8'h00);
    for (int s = 0; s < 16; s++)
    begin
      ch = (s == 0) ? 4'hc : 4'($random(seed));
      reg_wr(adcsq_pkg::ADDR_CTRL0, {4'h2, ch});
      reg_wr(adcsq_pkg::ADDR_CTRL1, {s[3:0], 4'h0});
      @(posedge clk);
      #1;
      `CHK(analog.src.kind, exp_kind(s[3:0]));
      `CHK(analog.chan_en, (exp_kind(s[3:0]) == 2'h0 && ch < 4'hc) ? 12'h1 << ch : 12'h0);
      if (exp_kind(s[3:0]) == 2'h1 || exp_kind(s[3:0]) == 2'h2)
        `CHK(analog.src.scale, 2'(s[1:0] - 2'h1));
    end
    for (int r = 0; r < 8; r++)
    begin
      reg_wr(adcsq_pkg::ADDR_CTRL2, {3'h4, r[2], r[1:0], r[1:0]});
      @(posedge clk);
      #1;
      `CHK(analog.ref_sel, r[1] ? 3'h4 : (r[0] ? 3'h2 : 3'h1));
      `CHK({analog.amp_pin, analog.amp_bandgap}, {~r[2], r[2]});
      `CHK({amp_pwr, amp_gain}, {1'b1, r[1:0]});
    end
    repeat (4)
    begin
      fs = 12'($random(seed));
      pullup_req <= 12'($random(seed));
      drive_req <= 12'($random(seed));
      reg_wr(adcsq_pkg::ADDR_PINFS_L, fs[7:0]);
      reg_wr(adcsq_pkg::ADDR_PINFS_H, {4'h0, fs[11:8]});
      repeat (2) @(posedge clk);
      #1;
      `CHK(pin.analog, fs);
      `CHK(pin.pullup_en, pullup_req & ~fs);
      `CHK(pin.drive_en, drive_req & ~fs);
    end
    run_conv(3'h0, 1'b0, 1'b1, 1'b1);
    run_conv(3'h2, 1'b1, 1'b1, 1'b0);
    run_conv(3'($random(seed)), 1'b0, 1'($random(seed)), 1'b1);
    // Power-down in mid-run must abort without touching the result or the flag.
    comp <= ~res[0];
    reg_wr(adcsq_pkg::ADDR_CTRL1, 8'h02);
    reg_wr(adcsq_pkg::ADDR_CTRL0, 8'ha0);
    reg_wr(adcsq_pkg::ADDR_CTRL0, 8'h20);
    repeat (30) @(posedge clk);
    // A write while the clock enable is low must be ignored and the run must stay frozen.
    clk_en <= 1'b0;
    reg_wr(adcsq_pkg::ADDR_CTRL0, 8'h00);
    #1;
    `CHK({busy, conv_pwr}, 2'h3);
    clk_en <= 1'b1;
    reg_wr(adcsq_pkg::ADDR_CTRL0, 8'h00);
    repeat (2) @(posedge clk);
    #1;
    `CHK({busy, conv_pwr}, 2'h0);
    reg_rd(adcsq_pkg::ADDR_RES_HI, rval);
    `CHK(rval, res[11:4]);
    reg_rd(adcsq_pkg::ADDR_IRQ, rval);
    `CHK(rval[0], 1'b0);
    report_and_stop();
  end
endmodule : adcsq_top_tb_top
